/* verilog/dpw_defs.svh */
/*
 * Constants for the dual waveform pin block: pin count, clock rates,
 * derived cycle counts, register offsets and interrupt bit positions.
 * Assumes a 25 MHz module clock and 8-bit byte addresses on a 32-bit bus.
 */
`ifndef DPW_DEFS_SVH
`define DPW_DEFS_SVH

// ==================================================================
// Sizes and timing
`define DPW_NPINS        8
`define DPW_NCH          2
`define DPW_CLK_HZ       25000000
`define DPW_TICK_HZ      1000000
`define DPW_SQ_MAX_HZ    4000000
`define DPW_TICK_DIV     (`DPW_CLK_HZ / `DPW_TICK_HZ)
`define DPW_SQ_MIN_HALF  ((`DPW_CLK_HZ + 2 * `DPW_SQ_MAX_HZ - 1) / (2 * `DPW_SQ_MAX_HZ))

// ==================================================================
// Register offsets
`define DPW_A_CH0        8'h00
`define DPW_A_CH1        8'h04
`define DPW_A_PERIOD     8'h08
`define DPW_A_HIGH0      8'h0C
`define DPW_A_HIGH1      8'h10
`define DPW_A_SQ_HALF    8'h14
`define DPW_A_DIR        8'h18
`define DPW_A_DOUT       8'h1C
`define DPW_A_DRIVE      8'h20
`define DPW_A_PULL       8'h24
`define DPW_A_WAKE_EN    8'h28
`define DPW_A_WAKE_POL   8'h2C
`define DPW_A_PIN_IN     8'h30
`define DPW_A_IRQ_STAT   8'h34
`define DPW_A_IRQ_MASK   8'h38

// ==================================================================
// Fields and codes
`define DPW_IRQ_WRAP     8
`define DPW_PULL_UP      2'h1
`define DPW_PULL_DOWN    2'h2

`endif

/* verilog/dpw_pkg.sv */
/*
 * Types of the dual waveform pin block: bus request, pin bundle,
 * channel configuration and the state records of each module.
 * Assumes dpw_defs.svh is on the include path.
 */
`include "dpw_defs.svh"

package dpw_pkg;

    typedef struct packed {
        logic                    en;
        logic                    mode;
        logic [2:0]              pin;
    } dpw_chan_t;

    typedef struct packed {
        logic                    wr;
        logic                    rd;
        logic [7:0]              addr;
        logic [31:0]             wdata;
    } dpw_bus_req_t;

    typedef struct packed {
        logic [`DPW_NPINS-1:0]   dout;
        logic [`DPW_NPINS-1:0]   oe_n;
        logic [`DPW_NPINS-1:0]   drive_hi;
        logic [`DPW_NPINS-1:0]   pull_up;
        logic [`DPW_NPINS-1:0]   pull_dn;
    } dpw_pin_out_t;

    typedef struct packed {
        logic [4:0]              cnt;
        logic                    tick;
    } dpw_tick_st_t;

    typedef struct packed {
        logic [15:0]             cnt;
        logic                    wave;
    } dpw_sq_st_t;

    typedef struct packed {
        dpw_chan_t [`DPW_NCH-1:0] ch;
        logic [31:0]             period;
        logic [`DPW_NCH-1:0][31:0] high;
        logic [15:0]             sq_half;
        logic [`DPW_NPINS-1:0]   dir;
        logic [`DPW_NPINS-1:0]   dout;
        logic [`DPW_NPINS-1:0]   drive;
        logic [2*`DPW_NPINS-1:0] pull;
        logic [`DPW_NPINS-1:0]   wake_en;
        logic [`DPW_NPINS-1:0]   wake_pol;
        logic [`DPW_NPINS-1:0]   sync1;
        logic [`DPW_NPINS-1:0]   sync2;
        logic [`DPW_NPINS:0]     irq_stat;
        logic [`DPW_NPINS:0]     irq_mask;
        logic [31:0]             cnt;
        dpw_pin_out_t            pins;
        logic                    wake;
        logic                    irq;
        logic [31:0]             rdata;
    } dpw_state_t;

endpackage : dpw_pkg

/* verilog/dpw_tick_gen.sv */
/*
 * Divider that turns the module clock into a one-cycle 1 MHz tick.
 * Assumes the module clock rate given in dpw_defs.svh.
 */
`timescale 1ns/1ps
`include "dpw_defs.svh"

module dpw_tick_gen (
    input  wire logic sys_clk_in,
    input  wire logic rst_n_in,
    output logic      tick_out
);

    dpw_pkg::dpw_tick_st_t q;
    dpw_pkg::dpw_tick_st_t d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.cnt == 5'(`DPW_TICK_DIV - 1)) begin
            d.cnt  = 5'h0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 5'h1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_out = q.tick;

endmodule : dpw_tick_gen

/* verilog/dpw_sq_gen.sv */
/*
 * Square wave source with equal high and low phases, each phase a
 * programmed number of module clocks. Assumes a 25 MHz module clock.
 */
`timescale 1ns/1ps
`include "dpw_defs.svh"

module dpw_sq_gen (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        en_in,
    input  wire logic [15:0] half_in,
    output logic             wave_out
);

    dpw_pkg::dpw_sq_st_t q;
    dpw_pkg::dpw_sq_st_t d;
    logic [15:0]         half_w;

    // Shorter phases would exceed the top frequency, so they are stretched.
    assign half_w = (half_in < 16'(`DPW_SQ_MIN_HALF)) ? 16'(`DPW_SQ_MIN_HALF) : half_in;

    always_comb begin
        d = q;
        if (!en_in || half_in == 16'h0) begin
            d.cnt  = 16'h0;
            d.wave = 1'b0;
        end else if (q.cnt >= half_w - 16'h1) begin
            d.cnt  = 16'h0;
            d.wave = !q.wave; // RULE9
        end else begin
            d.cnt = q.cnt + 16'h1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign wave_out = q.wave;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_SQ_MIN_PHASE: assert property ( // RULE9
        ($changed(q.wave) && en_in) |=> ($stable(q.wave) || !en_in || half_in == 16'h0 || $changed(half_in))[*3]
    ) else $error("square wave phase shorter than the minimum");

endmodule : dpw_sq_gen

/* verilog/dpw_top.sv */
/*
 * Dual waveform pin block: eight general pins with direction, drive,
 * pull and level wake-up settings, and two waveform channels that
 * take over a chosen pin with a PWM or square wave output.
 * Assumes a single 25 MHz clock, a synchronous active-low reset and a
 * register master that keeps to one-cycle strobes.
 */
// Functional notes
// RULE1 - A channel, when enabled, replaces the chosen pin's normal output behaviour.
// RULE2 - Two channels drive PWM or square wave on at most two pins.
// RULE3 - PWM period and high time use 32-bit counters.
// RULE4 - PWM counter advances on a 1 MHz tick.
// RULE5 - PWM frequency programmable, highest at a one-tick period.
// RULE6 - Duty cycle spans zero to one hundred percent inclusive.
// RULE7 - Both PWM channels share one period setting.
// RULE8 - Each PWM channel has its own high time.
// RULE9 - Square wave up to 4 MHz, always equal high and low phases.
// RULE10 - Every pin has its own input or output direction bit.
// RULE11 - Output pins have a standard or high drive bit.
// RULE12 - Each pin selects pull-up, pull-down or no pull.
// RULE13 - Each pin can wake on a selectable high or low level.
// RULE14 - Zero duty stays low, full duty stays high, no glitches.
`timescale 1ns/1ps
`include "dpw_defs.svh"

module dpw_top (
    input  wire logic                  sys_clk_in,
    input  wire dpw_pkg::dpw_bus_req_t bus_in,
    input  wire logic                  rst_n_in,
    input  wire logic [`DPW_NPINS-1:0] pins_in,
    output logic [31:0]                rd_data_out,
    output dpw_pkg::dpw_pin_out_t      pins_out,
    output logic                       wake_out,
    output logic                       irq_out
);

    // ==================================================================
    // State and helpers
    dpw_pkg::dpw_state_t       q;
    dpw_pkg::dpw_state_t       d;
    logic                      tick_w;
    logic [`DPW_NCH-1:0]       pwm_w;
    logic [`DPW_NCH-1:0]       sq_w;
    logic [`DPW_NCH-1:0]       wave_w;
    logic                      wrap_w;
    logic                      per_wr_w;
    logic [`DPW_NPINS-1:0]     hit_w;
    logic [`DPW_NPINS:0]       clr_w;

    dpw_tick_gen u_tick (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .tick_out   (tick_w)
    );

    // ==================================================================
    // Waveform channels
    genvar c;
    generate
        for (c = 0; c < `DPW_NCH; c++) begin : g_ch
            // Compare against the shared counter: high time zero never
            // matches and high time at or past the period always does.
            assign pwm_w[c] = (q.period != 32'h0) && (q.cnt < q.high[c]); // RULE6 RULE8 RULE14

            dpw_sq_gen u_sq (
                .sys_clk_in (sys_clk_in),
                .rst_n_in   (rst_n_in),
                .en_in      (q.ch[c].en && q.ch[c].mode),
                .half_in    (q.sq_half),
                .wave_out   (sq_w[c])
            );

            assign wave_w[c] = q.ch[c].mode ? sq_w[c] : pwm_w[c]; // RULE2 RULE9
        end
    endgenerate

    assign per_wr_w = bus_in.wr && (bus_in.addr == `DPW_A_PERIOD);
    assign wrap_w   = tick_w && (q.period != 32'h0) && (q.cnt >= q.period - 32'h1); // RULE5 RULE7
    assign hit_w    = q.wake_en & ~(q.sync2 ^ q.wake_pol); // RULE13
    assign clr_w    = (bus_in.wr && bus_in.addr == `DPW_A_IRQ_STAT) ? bus_in.wdata[`DPW_NPINS:0] : '0;

    // ==================================================================
    // Next state
    always_comb begin
        d = q;
        d.sync1 = pins_in;
        d.sync2 = q.sync1;

        if (q.period == 32'h0) begin
            d.cnt = 32'h0;
        end else if (tick_w) begin
            d.cnt = wrap_w ? 32'h0 : q.cnt + 32'h1; // RULE3 RULE4
        end

        if (bus_in.wr) begin
            case (bus_in.addr)
                `DPW_A_CH0:      d.ch[0] = bus_in.wdata[6:2]; // RULE1
                `DPW_A_CH1:      d.ch[1] = bus_in.wdata[6:2]; // RULE1
                `DPW_A_PERIOD: begin
                    d.period = bus_in.wdata; // RULE7
                    d.cnt    = 32'h0;
                end
                `DPW_A_HIGH0:    d.high[0]  = bus_in.wdata; // RULE8
                `DPW_A_HIGH1:    d.high[1]  = bus_in.wdata; // RULE8
                `DPW_A_SQ_HALF:  d.sq_half  = bus_in.wdata[15:0];
                `DPW_A_DIR:      d.dir      = bus_in.wdata[`DPW_NPINS-1:0]; // RULE10
                `DPW_A_DOUT:     d.dout     = bus_in.wdata[`DPW_NPINS-1:0];
                `DPW_A_DRIVE:    d.drive    = bus_in.wdata[`DPW_NPINS-1:0]; // RULE11
                `DPW_A_PULL:     d.pull     = bus_in.wdata[2*`DPW_NPINS-1:0]; // RULE12
                `DPW_A_WAKE_EN:  d.wake_en  = bus_in.wdata[`DPW_NPINS-1:0]; // RULE13
                `DPW_A_WAKE_POL: d.wake_pol = bus_in.wdata[`DPW_NPINS-1:0]; // RULE13
                `DPW_A_IRQ_MASK: d.irq_mask = bus_in.wdata[`DPW_NPINS:0];
                default: begin
                end
            endcase
        end

        // A new event in the same cycle as its clear is kept.
        d.irq_stat = (q.irq_stat & ~clr_w) | {wrap_w, hit_w};
        d.irq      = |(d.irq_stat & d.irq_mask);
        d.wake     = |hit_w;

        for (int p = 0; p < `DPW_NPINS; p++) begin
            d.pins.dout[p] = q.dout[p];
            d.pins.oe_n[p] = !q.dir[p]; // RULE10
            // Channel 0 is applied last so it wins when both pick one pin.
            for (int k = `DPW_NCH - 1; k >= 0; k--) begin
                if (q.ch[k].en && q.ch[k].pin == 3'(p)) begin
                    d.pins.dout[p] = wave_w[k]; // RULE1 RULE2
                    d.pins.oe_n[p] = 1'b0;      // RULE1
                end
            end
            d.pins.drive_hi[p] = q.drive[p] && !d.pins.oe_n[p]; // RULE11
            d.pins.pull_up[p]  = q.pull[2*p +: 2] == `DPW_PULL_UP;   // RULE12
            d.pins.pull_dn[p]  = q.pull[2*p +: 2] == `DPW_PULL_DOWN; // RULE12
        end

        d.rdata = 32'h0;
        if (bus_in.rd) begin
            case (bus_in.addr)
                `DPW_A_CH0:      d.rdata = {25'h0, q.ch[0], 2'h0};
                `DPW_A_CH1:      d.rdata = {25'h0, q.ch[1], 2'h0};
                `DPW_A_PERIOD:   d.rdata = q.period;
                `DPW_A_HIGH0:    d.rdata = q.high[0];
                `DPW_A_HIGH1:    d.rdata = q.high[1];
                `DPW_A_SQ_HALF:  d.rdata = {16'h0, q.sq_half};
                `DPW_A_DIR:      d.rdata = {24'h0, q.dir};
                `DPW_A_DOUT:     d.rdata = {24'h0, q.dout};
                `DPW_A_DRIVE:    d.rdata = {24'h0, q.drive};
                `DPW_A_PULL:     d.rdata = {16'h0, q.pull};
                `DPW_A_WAKE_EN:  d.rdata = {24'h0, q.wake_en};
                `DPW_A_WAKE_POL: d.rdata = {24'h0, q.wake_pol};
                `DPW_A_PIN_IN:   d.rdata = {24'h0, q.sync2};
                `DPW_A_IRQ_STAT: d.rdata = {23'h0, q.irq_stat};
                `DPW_A_IRQ_MASK: d.rdata = {23'h0, q.irq_mask};
                default:         d.rdata = 32'h0;
            endcase
        end
    end

    // ==================================================================
    // Registers
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            q           <= '0;
            q.pins.oe_n <= '1;
        end else begin
            q <= d;
        end
    end

    assign rd_data_out = q.rdata;
    assign pins_out    = q.pins;
    assign wake_out    = q.wake;
    assign irq_out     = q.irq;

    // ==================================================================
    // Checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_DUTY_ZERO: assert property ( // RULE14
        (q.ch[0].en && !q.ch[0].mode && q.high[0] == 32'h0) ##1 ($stable(q.ch[0]) && $stable(q.high[0]))
        |-> !q.pins.dout[q.ch[0].pin]
    ) else $error("zero duty pin went high");

    AST_DUTY_FULL: assert property ( // RULE14
        (q.ch[0].en && !q.ch[0].mode && q.period != 32'h0 && q.high[0] >= q.period)
        ##1 ($stable(q.ch[0]) && $stable(q.high[0]) && $stable(q.period))
        |-> q.pins.dout[q.ch[0].pin]
    ) else $error("full duty pin went low");

    AST_PIN_TAKEOVER: assert property ( // RULE1
        q.ch[0].en ##1 $stable(q.ch[0]) |-> !q.pins.oe_n[q.ch[0].pin]
    ) else $error("enabled channel does not drive its pin");

    AST_TICK_RATE: assert property ( // RULE4
        tick_w |-> ##1 (!tick_w)[*8] ##16 !tick_w ##1 tick_w
    ) else $error("tick spacing is not one microsecond");

    AST_CNT_HOLD: assert property ( // RULE4
        (!tick_w && !per_wr_w && q.period != 32'h0) |=> $stable(q.cnt)
    ) else $error("counter moved without a tick");

    AST_CNT_RANGE: assert property ( // RULE5
        (tick_w && !per_wr_w && q.period != 32'h0 && $stable(q.period)) |=> q.cnt < q.period
    ) else $error("counter ran past the shared period");

    AST_WAKE_SET: assert property ( // RULE13
        hit_w[7] |=> (q.irq_stat[7] && q.wake) ##1 wake_out || !hit_w[7]
    ) else $error("level wake did not latch");

    AST_DIR_INPUT: assert property ( // RULE10
        (!q.dir[1] && !(q.ch[0].en && q.ch[0].pin == 3'h1) && !(q.ch[1].en && q.ch[1].pin == 3'h1))
        |=> q.pins.oe_n[1]
    ) else $error("input pin is being driven");

    AST_IRQ_LEVEL: assert property (
        (|(q.irq_stat & q.irq_mask)) |-> irq_out
    ) else $error("interrupt low with an unmasked event set");

    AST_RD_ONE_CYCLE: assert property (
        !bus_in.rd |=> rd_data_out == 32'h0
    ) else $error("read data held past its cycle");

    // ==================================================================
    // Checks of the pin settings
    // The pull choice reaches the pins unchanged; high drive is only
    // granted while the pin is driven, so an input never sources current.
    AST_PULL_EXCL: assert property ( // RULE12
        (q.pins.pull_up & q.pins.pull_dn) == 8'h00
    ) else $error("both pulls enabled on one pin");

    AST_PULL_SEL: assert property ( // RULE12
        (q.pull[9:8] == `DPW_PULL_UP && q.pull[11:10] == `DPW_PULL_DOWN)
        |=> (q.pins.pull_up[4] && q.pins.pull_dn[5])
    ) else $error("pull setting not applied");

    AST_DRIVE_IDLE: assert property ( // RULE11
        (q.pins.drive_hi & q.pins.oe_n) == 8'h00
    ) else $error("high drive on a pin that is not driven");

    AST_DRIVE_SET: assert property ( // RULE11
        (q.drive[0] && q.dir[0])
        |=> q.pins.drive_hi[0]
    ) else $error("high drive not applied");

    AST_DIR_OUTPUT: assert property ( // RULE10
        q.dir[0]
        |=> !q.pins.oe_n[0]
    ) else $error("output pin is not driven");

    AST_DOUT_FOLLOW: assert property ( // RULE10
        (q.dir[3] && !(q.ch[0].en && q.ch[0].pin == 3'h3) && !(q.ch[1].en && q.ch[1].pin == 3'h3))
        |=> q.pins.dout[3] == $past(q.dout[3])
    ) else $error("output level does not follow its register");

    // ==================================================================
    // Checks of the channels, the counter and the events
    AST_CH1_TAKEOVER: assert property ( // RULE1
        q.ch[1].en ##1 $stable(q.ch[1])
        |-> !q.pins.oe_n[q.ch[1].pin]
    ) else $error("second channel does not drive its pin");

    AST_PWM_HIGH1: assert property ( // RULE8
        (q.ch[1].en && !q.ch[1].mode && q.period != 32'h0 && q.cnt < q.high[1] && q.ch[0].pin != q.ch[1].pin)
        |=> q.pins.dout[$past(q.ch[1].pin)]
    ) else $error("second channel low inside its high time");

    AST_PWM_LOW0: assert property ( // RULE8
        (q.ch[0].en && !q.ch[0].mode && q.cnt >= q.high[0])
        |=> !q.pins.dout[$past(q.ch[0].pin)]
    ) else $error("first channel high after its high time");

    AST_HIGH_WR: assert property ( // RULE8
        (bus_in.wr && bus_in.addr == `DPW_A_HIGH1)
        |=> (q.high[1] == $past(bus_in.wdata) && $stable(q.high[0]))
    ) else $error("high time write went astray");

    AST_PERIOD_WR: assert property ( // RULE7
        per_wr_w
        |=> (q.period == $past(bus_in.wdata) && q.cnt == 32'h0)
    ) else $error("period write did not restart the counter");

    AST_SQ_PIN: assert property ( // RULE9
        (q.ch[1].en && q.ch[1].mode && q.ch[0].pin != q.ch[1].pin)
        |=> q.pins.dout[$past(q.ch[1].pin)] == $past(sq_w[1])
    ) else $error("square wave not on its pin");

    AST_SQ_OFF: assert property ( // RULE9
        (q.sq_half == 16'h0)
        |=> sq_w == 2'h0
    ) else $error("square wave running with a zero phase");

    AST_SQ_IDLE: assert property ( // RULE9
        !(q.ch[0].en && q.ch[0].mode)
        |=> !sq_w[0]
    ) else $error("square wave on a channel not set for it");

    // The counter is the only time base of both PWM channels, so these
    // pin down its stepping, its wrap and its rest with no period.
    AST_TICK_PULSE: assert property ( // RULE4
        tick_w
        |=> !tick_w
    ) else $error("tick longer than one clock");

    AST_CNT_STEP: assert property ( // RULE4
        (tick_w && !wrap_w && !per_wr_w && q.period != 32'h0)
        |=> q.cnt == $past(q.cnt) + 32'h1
    ) else $error("counter did not step on a tick");

    AST_CNT_WRAP: assert property ( // RULE7
        wrap_w
        |=> q.cnt == 32'h0
    ) else $error("counter did not wrap at the period");

    AST_CNT_IDLE: assert property ( // RULE6
        (q.period == 32'h0)
        |=> q.cnt == 32'h0
    ) else $error("counter running with no period");

    AST_WRAP_EVENT: assert property (
        wrap_w
        |=> q.irq_stat[`DPW_IRQ_WRAP]
    ) else $error("period wrap not recorded");

    AST_STAT_CLEAR: assert property (
        (clr_w[7] && !hit_w[7])
        |=> !q.irq_stat[7]
    ) else $error("status bit survived its clear");

    AST_WAKE_RAISE: assert property ( // RULE13
        (hit_w != 8'h00)
        |=> wake_out
    ) else $error("wake low while a pin matches its level");

    AST_WAKE_IDLE: assert property ( // RULE13
        (hit_w == 8'h00)
        |=> !wake_out
    ) else $error("wake high with no matching pin");

    AST_RD_PERIOD: assert property (
        (bus_in.rd && bus_in.addr == `DPW_A_PERIOD)
        |=> rd_data_out == $past(q.period)
    ) else $error("period read back wrong");

    AST_RD_PIN_IN: assert property ( // RULE10
        (bus_in.rd && bus_in.addr == `DPW_A_PIN_IN)
        |=> rd_data_out == {24'h0, $past(q.sync2)}
    ) else $error("pin levels read back wrong");

endmodule : dpw_top

/* bench/dpw_load_model.sv */
/*
 * Load model for the eight general pins: resolves each wire from the
 * block's drive, an external driver and the pull resistors.
 * Assumes the pin bundle of dpw_top and one module clock.
 */
`timescale 1ns/1ps
`include "dpw_defs.svh"

module dpw_load_model (
    input  wire logic                  sys_clk_in,
    input  wire dpw_pkg::dpw_pin_out_t pins_in,
    input  wire logic [`DPW_NPINS-1:0] ext_en_in,
    input  wire logic [`DPW_NPINS-1:0] ext_val_in,
    output logic [`DPW_NPINS-1:0]      wire_out
);
    // ====================
    // Wire resolution
    logic [`DPW_NPINS-1:0] float_q = '0;

    // A floating wire toggles every clock, so nothing passes on a level nobody drives.
    always @(posedge sys_clk_in) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < `DPW_NPINS; i++) begin
            if (!pins_in.oe_n[i]) begin
                wire_out[i] = pins_in.dout[i];
            end else if (ext_en_in[i]) begin
                wire_out[i] = ext_val_in[i];
            end else if (pins_in.pull_up[i]) begin
                wire_out[i] = 1'b1;
            end else if (pins_in.pull_dn[i]) begin
                wire_out[i] = 1'b0;
            end else begin
                wire_out[i] = float_q[i];
            end
        end
    end
endmodule : dpw_load_model

/* bench/tb_dpw_top.sv */
/*
 * Self-checking bench for dpw_top: pin settings, PWM and square wave
 * channels, level wake-up and the interrupt status.
 * Assumes dpw_load_model stands on the pins and a 25 MHz clock.
 */
`timescale 1ns/1ps
`include "dpw_defs.svh"

module tb_dpw_top;
    logic                  sys_clk = 1'b0;
    logic                  rst_n;
    dpw_pkg::dpw_bus_req_t bus;
    logic [31:0]           rd_data;
    dpw_pkg::dpw_pin_out_t pins;
    logic [`DPW_NPINS-1:0] pin_lvl;
    logic                  wake;
    logic                  irq;
    logic [`DPW_NPINS-1:0] ext_en;
    logic [`DPW_NPINS-1:0] ext_val;
    int                    fails = 0;
    int                    n_tests = 0;
    int                    cycles = 0;
    int                    h;
    int                    c;

    dpw_top uut (.sys_clk_in(sys_clk), .bus_in(bus), .rst_n_in(rst_n), .pins_in(pin_lvl),
        .rd_data_out(rd_data), .pins_out(pins), .wake_out(wake), .irq_out(irq));
    dpw_load_model load (.sys_clk_in(sys_clk), .pins_in(pins), .ext_en_in(ext_en),
        .ext_val_in(ext_val), .wire_out(pin_lvl));

    always #20 sys_clk = ~sys_clk;

    // ====================
    // Shared tasks
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        bus <= '0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge sys_clk);
        bus <= '0;
        #1;
        chk(rd_data, e);
    endtask : rd_chk

    // Counts high samples and level changes of one pin over n clocks.
    task automatic meas(input int b, input int n);
        logic last;
        h = 0;
        c = 0;
        @(posedge sys_clk) #1;
        last = pins.dout[b];
        repeat (n) begin
            @(posedge sys_clk) #1;
            c += (pins.dout[b] !== last);
            h += (pins.dout[b] === 1'b1);
            last = pins.dout[b];
        end
    endtask : meas

    // ====================
    // Scenarios
    task automatic t_reset();
        chk(32'(pins.oe_n), 32'hFF);
        rd_chk(`DPW_A_DIR, 32'h0);
        rd_chk(8'h3C, 32'h0);
        chk(32'({wake, irq}), 32'h0);
    endtask : t_reset

    task automatic t_gpio();
        wr(`DPW_A_DIR, 32'h0F);
        wr(`DPW_A_DOUT, 32'h05);
        wr(`DPW_A_DRIVE, 32'h13);
        wr(`DPW_A_PULL, 32'h3900);
        repeat (4) @(posedge sys_clk);
        chk(32'(pins.oe_n), 32'hF0);
        chk(32'(pins.dout[3:0]), 32'h5);
        chk(32'(pins.drive_hi), 32'h03);
        chk(32'({pins.pull_up, pins.pull_dn}), 32'h1020);
        rd_chk(`DPW_A_PIN_IN, 32'h15);
        wr(`DPW_A_PIN_IN, 32'hFF);
        rd_chk(`DPW_A_PIN_IN, 32'h15);
    endtask : t_gpio

    task automatic t_pwm();
        wr(`DPW_A_PERIOD, 32'hFFFFFFFF);
        rd_chk(`DPW_A_PERIOD, 32'hFFFFFFFF);
        wr(`DPW_A_PERIOD, 32'h4);
        wr(`DPW_A_HIGH0, 32'h1);
        wr(`DPW_A_HIGH1, 32'h3);
        wr(`DPW_A_CH0, 32'h48);
        wr(`DPW_A_CH1, 32'h54);
        repeat (4) @(posedge sys_clk);
        chk(32'(pins.oe_n), 32'hD0);
        meas(2, 100);
        chk(h, 25);
        chk(c, 2);
        meas(5, 100);
        chk(h, 75);
        chk(c, 2);
        rd_chk(`DPW_A_IRQ_STAT, 32'h100);
        wr(`DPW_A_HIGH0, 32'h0);
        wr(`DPW_A_HIGH1, 32'h4);
        repeat (4) @(posedge sys_clk);
        meas(2, 200);
        chk(h + c, 0);
        meas(5, 200);
        chk(h + c, 200);
        wr(`DPW_A_PERIOD, 32'h2);
        wr(`DPW_A_HIGH0, 32'h1);
        meas(2, 100);
        chk(h, 50);
        chk(c, 4);
        wr(`DPW_A_HIGH0, 32'h2);
        repeat (4) @(posedge sys_clk);
        meas(2, 100);
        chk(h, 100);
        chk(c, 0);
        wr(`DPW_A_CH0, 32'h0);
        wr(`DPW_A_PERIOD, 32'h0);
    endtask : t_pwm

    task automatic t_square();
        wr(`DPW_A_SQ_HALF, 32'h6);
        wr(`DPW_A_CH1, 32'h74);
        repeat (4) @(posedge sys_clk);
        meas(5, 120);
        chk(h, 60);
        chk(c, 20);
        wr(`DPW_A_SQ_HALF, 32'h1);
        repeat (4) @(posedge sys_clk);
        meas(5, 80);
        chk(h, 40);
        chk(c, 20);
        wr(`DPW_A_SQ_HALF, 32'h0);
        repeat (4) @(posedge sys_clk);
        meas(5, 80);
        chk(h + c, 0);
        wr(`DPW_A_CH1, 32'h0);
    endtask : t_square

    task automatic t_wake();
        wr(`DPW_A_IRQ_STAT, 32'h1FF);
        wr(`DPW_A_WAKE_POL, 32'h80);
        wr(`DPW_A_WAKE_EN, 32'h80);
        wr(`DPW_A_IRQ_MASK, 32'h80);
        repeat (4) @(posedge sys_clk);
        chk(32'({wake, irq}), 32'h0);
        ext_val[7] <= 1'b1;
        repeat (5) @(posedge sys_clk) #1;
        chk(32'({wake, irq}), 32'h3);
        rd_chk(`DPW_A_IRQ_STAT, 32'h80);
        ext_val[7] <= 1'b0;
        repeat (5) @(posedge sys_clk) #1;
        chk(32'({wake, irq}), 32'h1);
        wr(`DPW_A_IRQ_STAT, 32'h80);
        repeat (2) @(posedge sys_clk) #1;
        chk(32'(irq), 32'h0);
        wr(`DPW_A_WAKE_POL, 32'h0);
        wr(`DPW_A_IRQ_MASK, 32'h0);
        repeat (4) @(posedge sys_clk) #1;
        chk(32'({wake, irq}), 32'h2);
        rd_chk(`DPW_A_IRQ_STAT, 32'h80);
    endtask : t_wake

    // ====================
    // Main sequence and hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        bus = '0;
        rst_n = 1'b0;
        ext_en = 8'hC0;
        ext_val = 8'h00;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk) #1;
        t_reset();
        t_gpio();
        t_pwm();
        t_square();
        t_wake();
        conclude();
    end
endmodule : tb_dpw_top
